// File: hw/sbp_pkg.sv
// Package of constants and types for the static branch predictor with return stack
package sbp_pkg;
	localparam int SBP_ADDR_W = 32;
	localparam int SBP_RAS_DEPTH = 16;
	localparam int SBP_RAS_PTR_W = 4;
	localparam logic [SBP_RAS_PTR_W-1:0] SBP_PTR_RST = 4'h0;
	localparam logic [SBP_RAS_PTR_W:0] SBP_CNT_RST = 5'h00;
	localparam logic [SBP_ADDR_W-1:0] SBP_ADDR_RST = 32'h00000000;

	// Branch kind from decode
	typedef enum logic [2:0] {
		SBP_BR_NONE = 3'h0,
		SBP_BR_COND = 3'h1,
		SBP_BR_INDIRECT = 3'h2,
		SBP_BR_CALL = 3'h3,
		SBP_BR_RET = 3'h4,
		SBP_BR_JUMP = 3'h5
	} sbp_kind_t;

	// Source of a prediction
	typedef enum logic [3:0] {
		SBP_SRC_NONE = 4'h1,
		SBP_SRC_BTB = 4'h2,
		SBP_SRC_STATIC = 4'h4,
		SBP_SRC_RAS = 4'h8
	} sbp_src_t;
endpackage : sbp_pkg

// File: hw/sbp_ras.sv
// Circular return address stack
`timescale 1ns/10ps
module sbp_ras
	import sbp_pkg::*;
#(
	parameter int DEPTH = SBP_RAS_DEPTH,
	parameter int PTR_W = SBP_RAS_PTR_W,
	parameter int ADDR_W = SBP_ADDR_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Stack operations
	input wire logic push,
	input wire logic pop,
	input wire logic [ADDR_W-1:0] push_addr,
	// Stack view
	output logic [ADDR_W-1:0] top_addr,
	output logic top_valid
);
	typedef struct packed {
		logic [PTR_W-1:0] ptr;
		logic [PTR_W:0] count;
	} sbp_ras_st_t;

	sbp_ras_st_t st;
	sbp_ras_st_t next_st;
	logic [ADDR_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0] top_idx;

	assign top_idx = st.ptr - {{(PTR_W-1){1'b0}}, 1'b1};
	assign top_addr = mem[top_idx];
	assign top_valid = (st.count != '0);

	always_comb begin
		next_st = st;
		if (push) begin
			// Wrap overwrites oldest entry when full
			next_st.ptr = st.ptr + {{(PTR_W-1){1'b0}}, 1'b1};
			if (st.count != DEPTH[PTR_W:0]) begin
				next_st.count = st.count + {{PTR_W{1'b0}}, 1'b1};
			end
		end else if (pop && top_valid) begin
			next_st.ptr = top_idx;
			next_st.count = st.count - {{PTR_W{1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st.ptr <= '0;
			st.count <= '0;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[st.ptr] <= push_addr;
		end
	end

	a_count_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st.count <= DEPTH[PTR_W:0])
		else $error("stack count above depth");
	a_push_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
		push |=> (top_valid && top_addr == $past(push_addr)))
		else $error("pushed address not on top");
endmodule : sbp_ras

// File: hw/sbp_top.sv
// Static branch predictor with return address stack
`timescale 1ns/10ps
module sbp_top
	import sbp_pkg::*;
#(
	parameter int ADDR_W = SBP_ADDR_W,
	parameter int RAS_DEPTH = SBP_RAS_DEPTH,
	parameter int RAS_PTR_W = SBP_RAS_PTR_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Decoded branch from fetch front end
	input wire logic br_valid,
	input wire logic [2:0] br_kind,
	input wire logic [ADDR_W-1:0] br_pc,
	input wire logic [ADDR_W-1:0] br_target,
	input wire logic [ADDR_W-1:0] br_next_pc,
	// Target buffer lookup result
	input wire logic btb_hit,
	input wire logic btb_taken,
	input wire logic [ADDR_W-1:0] btb_target,
	// Branch resolution from execute
	input wire logic res_valid,
	input wire logic [2:0] res_kind,
	input wire logic res_taken,
	input wire logic res_btb_hit,
	input wire logic [ADDR_W-1:0] res_pc,
	input wire logic [ADDR_W-1:0] res_target,
	// Registered prediction
	output logic pred_valid,
	output logic pred_taken,
	output logic [ADDR_W-1:0] pred_target,
	output logic [3:0] pred_src,
	// Target buffer allocation request
	output logic alloc_valid,
	output logic [ADDR_W-1:0] alloc_pc,
	output logic [ADDR_W-1:0] alloc_target
);
	typedef struct packed {
		logic pred_valid;
		logic pred_taken;
		logic [ADDR_W-1:0] pred_target;
		sbp_src_t pred_src;
		logic alloc_valid;
		logic [ADDR_W-1:0] alloc_pc;
		logic [ADDR_W-1:0] alloc_target;
	} sbp_st_t;

	sbp_st_t st;
	sbp_st_t next_st;
	sbp_kind_t kind;
	sbp_kind_t rkind;
	logic ras_push;
	logic ras_pop;
	logic [ADDR_W-1:0] ras_top;
	logic ras_top_valid;
	logic backward;

	assign kind = sbp_kind_t'(br_kind);
	assign rkind = sbp_kind_t'(res_kind);
	assign backward = (br_target < br_pc);
	assign ras_push = br_valid && (kind == SBP_BR_CALL);
	assign ras_pop = br_valid && (kind == SBP_BR_RET);

	sbp_ras #(
		.DEPTH(RAS_DEPTH),
		.PTR_W(RAS_PTR_W),
		.ADDR_W(ADDR_W)
	) u_ras (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.push(ras_push),
		.pop(ras_pop),
		.push_addr(br_next_pc),
		.top_addr(ras_top),
		.top_valid(ras_top_valid)
	);

	always_comb begin
		next_st = st;
		next_st.pred_valid = br_valid;
		next_st.pred_taken = 1'b0;
		next_st.pred_target = br_next_pc;
		next_st.pred_src = SBP_SRC_NONE;
		if (br_valid) begin
			if (kind == SBP_BR_RET && ras_top_valid) begin
				// Return target from stack
				next_st.pred_taken = 1'b1;
				next_st.pred_target = ras_top;
				next_st.pred_src = SBP_SRC_RAS;
			end else if (btb_hit) begin
				// Buffer wins; indirect gets the target allocated at its last taken miss
				next_st.pred_taken = btb_taken;
				next_st.pred_target = btb_taken ? btb_target : br_next_pc;
				next_st.pred_src = SBP_SRC_BTB;
			end else begin
				// Miss: buffer gives nothing, static logic decides
				next_st.pred_src = SBP_SRC_STATIC;
				if (kind == SBP_BR_COND) begin
					next_st.pred_taken = backward;
					next_st.pred_target = backward ? br_target : br_next_pc;
				end else if (kind == SBP_BR_CALL || kind == SBP_BR_JUMP) begin
					next_st.pred_taken = 1'b1;
					next_st.pred_target = br_target;
				end else begin
					next_st.pred_taken = 1'b0;
					next_st.pred_target = br_next_pc;
				end
			end
		end
		// Allocate only on a taken resolution that missed and is not a return
		next_st.alloc_valid = res_valid && res_taken && !res_btb_hit && (rkind != SBP_BR_RET);
		next_st.alloc_pc = res_pc;
		next_st.alloc_target = res_target;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st.pred_valid <= 1'b0;
			st.pred_taken <= 1'b0;
			st.pred_target <= SBP_ADDR_RST;
			st.pred_src <= SBP_SRC_NONE;
			st.alloc_valid <= 1'b0;
			st.alloc_pc <= SBP_ADDR_RST;
			st.alloc_target <= SBP_ADDR_RST;
		end else begin
			st <= next_st;
		end
	end

	assign pred_valid = st.pred_valid;
	assign pred_taken = st.pred_taken;
	assign pred_target = st.pred_target;
	assign pred_src = st.pred_src;
	assign alloc_valid = st.alloc_valid;
	assign alloc_pc = st.alloc_pc;
	assign alloc_target = st.alloc_target;

	a_no_alloc_nt: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(res_valid && !res_taken) |=> !alloc_valid)
		else $error("allocation for not taken branch");
	a_miss_static: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(br_valid && !btb_hit && kind != SBP_BR_RET) |=> pred_src == SBP_SRC_STATIC)
		else $error("miss not predicted statically");
	a_fwd_nt: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(br_valid && !btb_hit && kind == SBP_BR_COND && !backward) |=> !pred_taken)
		else $error("forward branch predicted taken");
	a_bwd_t: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(br_valid && !btb_hit && kind == SBP_BR_COND && backward)
		|=> (pred_taken && pred_target == $past(br_target)))
		else $error("backward branch not predicted taken");
	a_ind_nt: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(br_valid && !btb_hit && kind == SBP_BR_INDIRECT)
		|=> (!pred_taken && pred_target == $past(br_next_pc)))
		else $error("indirect miss predicted taken");
	a_call_ret: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(br_valid && kind == SBP_BR_CALL) ##1 (br_valid && kind == SBP_BR_RET)
		|=> (pred_taken && pred_target == $past(br_next_pc, 2)))
		else $error("return target not from stack");
	a_ind_hit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(br_valid && btb_hit && btb_taken && kind == SBP_BR_INDIRECT)
		|=> pred_target == $past(btb_target))
		else $error("indirect hit ignores buffer target");
	a_hit_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(br_valid && btb_hit && kind != SBP_BR_RET) |=> pred_taken == $past(btb_taken))
		else $error("hit overridden by static");

	c_bwd: cover property (@(posedge clk_sys) disable iff (!rst_n)
		br_valid && !btb_hit && kind == SBP_BR_COND && backward);
	c_ret: cover property (@(posedge clk_sys) disable iff (!rst_n)
		pred_valid && pred_src == SBP_SRC_RAS);
	c_alloc: cover property (@(posedge clk_sys) disable iff (!rst_n) alloc_valid);
endmodule : sbp_top

// File: testbench/sbp_btb_model.sv
// Target buffer model with one entry, filled by allocation requests
`timescale 1ns/10ps
module sbp_btb_model
	import sbp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Lookup
	input wire logic [SBP_ADDR_W-1:0] look_pc,
	output logic hit,
	output logic taken,
	output logic [SBP_ADDR_W-1:0] target,
	// Allocation
	input wire logic alloc_valid,
	input wire logic [SBP_ADDR_W-1:0] alloc_pc,
	input wire logic [SBP_ADDR_W-1:0] alloc_target
);
	logic ent_valid;
	logic [SBP_ADDR_W-1:0] ent_pc;
	logic [SBP_ADDR_W-1:0] ent_target;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ent_valid <= 1'b0;
		end else if (alloc_valid) begin
			ent_valid <= 1'b1;
			ent_pc <= alloc_pc;
			ent_target <= alloc_target;
		end
	end
	assign hit = ent_valid && (look_pc == ent_pc);
	assign taken = hit;
	// A miss shows no stale target
	assign target = hit ? ent_target : ~ent_target;
endmodule : sbp_btb_model

// File: testbench/tb_static_branch_predictor_ras.sv
// Testbench of the static branch predictor with return stack
`timescale 1ns/10ps
module tb_static_branch_predictor_ras;
	import sbp_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic br_valid = 1'b0;
	logic [2:0] br_kind = 3'h0;
	logic [31:0] br_pc = 32'h0;
	logic [31:0] br_target = 32'h0;
	logic [31:0] br_next_pc = 32'h0;
	logic btb_hit;
	logic btb_taken;
	logic [31:0] btb_target;
	logic res_valid = 1'b0;
	logic [2:0] res_kind = 3'h0;
	logic res_taken = 1'b0;
	logic res_btb_hit = 1'b0;
	logic [31:0] res_pc = 32'h0;
	logic [31:0] res_target = 32'h0;
	logic pred_valid;
	logic pred_taken;
	logic [31:0] pred_target;
	logic [3:0] pred_src;
	logic alloc_valid;
	logic [31:0] alloc_pc;
	logic [31:0] alloc_target;
	int n_mismatch = 0;
	int comparisons = 0;
	always #12.5 clk_sys = ~clk_sys;
	sbp_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .br_valid(br_valid), .br_kind(br_kind),
		.br_pc(br_pc), .br_target(br_target), .br_next_pc(br_next_pc), .btb_hit(btb_hit),
		.btb_taken(btb_taken), .btb_target(btb_target), .res_valid(res_valid),
		.res_kind(res_kind), .res_taken(res_taken), .res_btb_hit(res_btb_hit),
		.res_pc(res_pc), .res_target(res_target), .pred_valid(pred_valid),
		.pred_taken(pred_taken), .pred_target(pred_target), .pred_src(pred_src),
		.alloc_valid(alloc_valid), .alloc_pc(alloc_pc), .alloc_target(alloc_target));
	sbp_btb_model btb_u (.clk_sys(clk_sys), .rst_n(rst_n), .look_pc(br_pc), .hit(btb_hit),
		.taken(btb_taken), .target(btb_target), .alloc_valid(alloc_valid),
		.alloc_pc(alloc_pc), .alloc_target(alloc_target));
	task summarize();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	task chk(input logic [37:0] got, input logic [37:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One decoded branch, prediction judged one cycle later
	task pred(input logic [2:0] k, input logic [31:0] pc, input logic [31:0] t,
		input logic [31:0] n, input logic tk, input logic [31:0] et, input logic [3:0] es);
		@(posedge clk_sys);
		br_valid <= 1'b1;
		br_kind <= k;
		br_pc <= pc;
		br_target <= t;
		br_next_pc <= n;
		@(posedge clk_sys);
		br_valid <= 1'b0;
		#1;
		chk({pred_valid, pred_taken, pred_src, pred_target}, {1'b1, tk, es, et});
	endtask : pred
	// One resolution, allocation pulse judged one cycle later
	task resolve(input logic [2:0] k, input logic tk, input logic h, input logic [31:0] pc,
		input logic [31:0] t, input logic ea);
		@(posedge clk_sys);
		res_valid <= 1'b1;
		res_kind <= k;
		res_taken <= tk;
		res_btb_hit <= h;
		res_pc <= pc;
		res_target <= t;
		@(posedge clk_sys);
		res_valid <= 1'b0;
		#1;
		chk({5'h0, alloc_valid, alloc_pc}, {5'h0, ea, pc});
		if (ea) begin
			chk({6'h0, alloc_target}, {6'h0, t});
		end
	endtask : resolve
	task t_static();
		pred(SBP_BR_COND, 32'h100, 32'h80, 32'h104, 1'b1, 32'h80, SBP_SRC_STATIC);
		pred(SBP_BR_COND, 32'h100, 32'h180, 32'h104, 1'b0, 32'h104, SBP_SRC_STATIC);
		pred(SBP_BR_COND, 32'h100, 32'h100, 32'h104, 1'b0, 32'h104, SBP_SRC_STATIC);
		pred(SBP_BR_INDIRECT, 32'h200, 32'h0, 32'h204, 1'b0, 32'h204, SBP_SRC_STATIC);
		pred(SBP_BR_JUMP, 32'h300, 32'h40, 32'h304, 1'b1, 32'h40, SBP_SRC_STATIC);
	endtask : t_static
	task t_alloc();
		resolve(SBP_BR_COND, 1'b0, 1'b0, 32'h200, 32'h300, 1'b0);
		resolve(SBP_BR_INDIRECT, 1'b1, 1'b1, 32'h200, 32'h300, 1'b0);
		resolve(SBP_BR_INDIRECT, 1'b1, 1'b0, 32'h200, 32'h300, 1'b1);
		pred(SBP_BR_INDIRECT, 32'h200, 32'h0, 32'h204, 1'b1, 32'h300, SBP_SRC_BTB);
		pred(SBP_BR_COND, 32'h200, 32'h400, 32'h204, 1'b1, 32'h300, SBP_SRC_BTB);
	endtask : t_alloc
	// Seventeen nested calls, sixteen matched returns, then one return on the empty stack
	task t_stack();
		for (int i = 0; i < 17; i++) begin
			pred(SBP_BR_CALL, 32'h1000, 32'h8000, 32'h2000 + i, 1'b1, 32'h8000, SBP_SRC_STATIC);
		end
		for (int i = 16; i > 0; i--) begin
			pred(SBP_BR_RET, 32'h5000, 32'h0, 32'h5004, 1'b1, 32'h2000 + i, SBP_SRC_RAS);
		end
		pred(SBP_BR_RET, 32'h5000, 32'h0, 32'h5004, 1'b0, 32'h5004, SBP_SRC_STATIC);
	endtask : t_stack
	// Call and matching return on consecutive cycles
	task t_pair();
		@(posedge clk_sys);
		br_valid <= 1'b1;
		br_kind <= SBP_BR_CALL;
		br_pc <= 32'h600;
		br_target <= 32'h700;
		br_next_pc <= 32'h604;
		@(posedge clk_sys);
		br_kind <= SBP_BR_RET;
		br_pc <= 32'h780;
		br_target <= 32'h0;
		br_next_pc <= 32'h784;
		#1;
		chk({pred_valid, pred_taken, pred_src, pred_target}, {2'b11, SBP_SRC_STATIC, 32'h700});
		@(posedge clk_sys);
		br_valid <= 1'b0;
		#1;
		chk({pred_valid, pred_taken, pred_src, pred_target}, {2'b11, SBP_SRC_RAS, 32'h604});
	endtask : t_pair
	// Reset in mid-run empties the stack, so a later return is predicted statically
	task t_reset();
		pred(SBP_BR_CALL, 32'h900, 32'hA00, 32'h904, 1'b1, 32'hA00, SBP_SRC_STATIC);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		pred(SBP_BR_RET, 32'hA80, 32'h0, 32'hA84, 1'b0, 32'hA84, SBP_SRC_STATIC);
	endtask : t_reset
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		@(posedge clk_sys);
		#1;
		chk({pred_valid, pred_taken, pred_src, pred_target}, {2'b00, SBP_SRC_NONE, 32'h0});
		t_static();
		t_alloc();
		t_stack();
		t_pair();
		t_reset();
		summarize();
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_mismatch++;
		summarize();
	end
endmodule : tb_static_branch_predictor_ras
